// ### cfbo_pkg.sv
package cfbo_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 20;
   // Base tick of the follow period, one step of the period setting
   localparam int TICK_PERIOD_NS = 100000;
   // Least time, so round up
   localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Parameter indices
   // ==========================================================
   localparam logic [15:0] IDX_MODE_SEL = 16'h00cc;
   localparam logic [15:0] IDX_ACTION_SEL = 16'h0296;
   localparam logic [15:0] IDX_BUS_OFF_SEL = 16'h02bf;
   localparam logic [15:0] IDX_ROLE_SEL = 16'h02c0;
   localparam logic [15:0] IDX_IDENT = 16'h02c1;
   localparam logic [15:0] IDX_PERIOD = 16'h02c2;

   // ==========================================================
   // Values, ranges and reset values
   // ==========================================================
   localparam logic [15:0] RECOVERY_MANUAL = 16'h0000;
   localparam logic [15:0] RECOVERY_AUTO = 16'h0001;
   localparam logic [15:0] ROLE_OFF = 16'h0000;
   localparam logic [15:0] ROLE_PROD_REAL = 16'h0001;
   localparam logic [15:0] ROLE_PROD_VIRT = 16'h0002;
   localparam logic [15:0] ROLE_CONSUMER = 16'h0003;
   localparam logic [15:0] ACTION_ALARM = 16'h0000;
   localparam logic [15:0] ACTION_FAULT = 16'h0001;
   localparam logic [15:0] ACTION_STOP = 16'h0002;
   localparam logic [15:0] ACTION_DISABLE = 16'h0003;
   localparam logic [15:0] MODE_LADDER = 16'h0004;
   localparam logic [15:0] IDENT_MIN = 16'h0181;
   localparam logic [15:0] IDENT_MAX = 16'h01ff;
   // Period in steps of one tick (0.2 ms to 5.0 ms)
   localparam logic [15:0] PERIOD_MIN = 16'h0002;
   localparam logic [15:0] PERIOD_MAX = 16'h0032;

   localparam logic [15:0] BUS_OFF_SEL_RST = 16'h0000;
   localparam logic [15:0] ROLE_SEL_RST = 16'h0000;
   localparam logic [15:0] IDENT_RST = 16'h0181;
   localparam logic [15:0] PERIOD_RST = 16'h000a;
   localparam logic [15:0] ACTION_SEL_RST = 16'h0000;
   localparam logic [15:0] MODE_SEL_RST = 16'h0002;

   localparam int FIFO_DEPTH = 8;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic [31:0] pos;
      logic [31:0] spd;
   } cfbo_axis_t;

   typedef struct packed {
      logic [10:0] id;
      cfbo_axis_t axis;
   } cfbo_frame_t;

   localparam int FRAME_W = $bits(cfbo_frame_t);

   typedef enum logic [1:0] {
      CST_RUN,
      CST_RESTART,
      CST_DEAD
   } cfbo_comm_st_t;

endpackage

// ### cfbo_fifo.sv
module cfbo_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } cfbo_fifo_st_t;

   cfbo_fifo_st_t st_q, st_d;
   logic push, pop, load;

   // ==========================================================
   // Storage and registered output stage
   // ==========================================================
   // Output word sits in a register so the reader never sees memory timing
   always_comb begin
      st_d = st_q;
      push = in_valid_in && (st_q.count != (AW + 1)'(DEPTH));
      load = !st_q.out_valid || out_ready_in;
      pop = load && (st_q.count != '0);
      if (push) begin
         st_d.mem[st_q.wr_ptr] = in_data_in;
         st_d.wr_ptr = st_q.wr_ptr + 1'b1;
      end
      if (load) begin
         st_d.out_valid = (st_q.count != '0);
         st_d.out_data = st_q.mem[st_q.rd_ptr];
      end
      if (pop) begin
         st_d.rd_ptr = st_q.rd_ptr + 1'b1;
      end
      st_d.count = st_q.count + (AW + 1)'(push) - (AW + 1)'(pop);
      // Flush drops everything, including the word on the output
      if (flush_in) begin
         st_d.wr_ptr = '0;
         st_d.rd_ptr = '0;
         st_d.count = '0;
         st_d.out_valid = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign in_ready_out = (st_q.count != (AW + 1)'(DEPTH));
   assign out_valid_out = st_q.out_valid;
   assign out_data_out = st_q.out_data;

endmodule // cfbo_fifo

// ### cfbo_follow_ctrl.sv
// Contract
// - Manual recovery: alarm and action (fault action without alarm), comm dead until reset
// - Automatic recovery: restart, no alarm, no action
// - Role decode: off, real, virtual, consumer
// - Producer sends real or virtual axis data
// - Consumer passes received data to gearing block
// - Producer or consumer enters operational state itself
// - Identifier accepted only from 385 to 511
// - One common identifier; others ignored by consumer
// - Producer sends once per period, 0.2-5.0 ms
// - Consumer ignores the period setting
// - Producer telegrams are reference for all consumers
// - Consumer applies data only in ladder mode
// - Master writes take effect at once, no restart
// - Error action decode: alarm, fault, stop, disable
module cfbo_follow_ctrl
   import cfbo_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Parameter access, local keypad or network object writes alike
   input wire logic par_wr_in,
   input wire logic par_rd_in,
   input wire logic [15:0] par_idx_in,
   input wire logic [15:0] par_wdata_in,
   output logic [15:0] par_rdata_out,
   output logic par_ack_out,
   output logic par_err_out,
   // From the CAN controller
   input wire logic bus_off_in,
   input wire logic rx_valid_in,
   input wire logic [10:0] rx_id_in,
   input wire cfbo_axis_t rx_axis_in,
   // Transmit queue towards the CAN controller
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output cfbo_frame_t tx_frame_out,
   // Axis sources for the producer, and the fault reset input
   input wire cfbo_axis_t real_axis_in,
   input wire cfbo_axis_t virt_axis_in,
   input wire logic fault_reset_in,
   // Status and actions
   output logic comm_enabled_out,
   output logic can_restart_out,
   output logic bus_off_alarm_out,
   output logic comm_fault_out,
   output logic stop_cmd_out,
   output logic disable_cmd_out,
   output logic nmt_operational_out,
   output logic gear_valid_out,
   output cfbo_axis_t gear_axis_out
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      // Settings
      logic [15:0] bus_off_sel;
      logic [15:0] role_sel;
      logic [15:0] ident;
      logic [15:0] period;
      logic [15:0] action_sel;
      logic [15:0] mode_sel;

      // Port answer
      logic [15:0] rdata;
      logic ack;
      logic err;

      // Link and timers
      cfbo_comm_st_t comm;
      logic comm_en;
      logic [15:0] tick_cnt;
      logic [15:0] period_cnt;
      logic pend;
      cfbo_frame_t frame;

      // Actions
      logic alarm;
      logic fault;
      logic stop;
      logic disable_cmd;
      logic restart;
      logic nmt_op;
      logic gear_valid;
      cfbo_axis_t gear_axis;
   } cfbo_st_t;

   cfbo_st_t st_q, st_d;

   logic fifo_in_ready;
   logic fifo_flush;
   logic fifo_push;
   logic tick;
   logic producer;
   logic consumer;
   logic running;

   // Decode of the role setting, shared by several paths
   function automatic logic is_producer(input logic [15:0] role);
      return (role == ROLE_PROD_REAL) || (role == ROLE_PROD_VIRT);
   endfunction

   function automatic logic is_consumer(input logic [15:0] role);
      return role == ROLE_CONSUMER;
   endfunction

   // Range checks for writes that carry a bounded value
   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_d = st_q;
      producer = is_producer(st_q.role_sel);
      consumer = is_consumer(st_q.role_sel);
      running = (st_q.comm == CST_RUN);
      tick = (st_q.tick_cnt == 16'(TICK_CYC - 1));
      fifo_push = st_q.pend && running && producer;
      fifo_flush = (st_q.comm == CST_DEAD);

      // Pulses default low
      st_d.ack = 1'b0;
      st_d.err = 1'b0;
      st_d.restart = 1'b0;
      st_d.gear_valid = 1'b0;

      // Parameter writes apply in the next cycle, no restart needed
      if (par_wr_in) begin
         st_d.ack = 1'b1;
         unique case (par_idx_in)
            IDX_BUS_OFF_SEL: begin
               if (par_wdata_in <= RECOVERY_AUTO) begin
                  st_d.bus_off_sel = par_wdata_in;
               end else begin
                  st_d.err = 1'b1;
               end
            end
            IDX_ROLE_SEL: begin
               if (par_wdata_in <= ROLE_CONSUMER) begin
                  st_d.role_sel = par_wdata_in;
               end else begin
                  st_d.err = 1'b1;
               end
            end
            IDX_IDENT: begin
               // Out of range identifiers are refused, old value kept
               if (in_range(par_wdata_in, IDENT_MIN, IDENT_MAX)) begin
                  st_d.ident = par_wdata_in;
               end else begin
                  st_d.err = 1'b1;
               end
            end
            IDX_PERIOD: begin
               if (in_range(par_wdata_in, PERIOD_MIN, PERIOD_MAX)) begin
                  st_d.period = par_wdata_in;
               end else begin
                  st_d.err = 1'b1;
               end
            end
            IDX_ACTION_SEL: begin
               if (par_wdata_in <= ACTION_DISABLE) begin
                  st_d.action_sel = par_wdata_in;
               end else begin
                  st_d.err = 1'b1;
               end
            end
            IDX_MODE_SEL: begin
               st_d.mode_sel = par_wdata_in;
            end
            default: begin
               st_d.err = 1'b1;
            end
         endcase
      end else if (par_rd_in) begin
         st_d.ack = 1'b1;
         unique case (par_idx_in)
            IDX_BUS_OFF_SEL: st_d.rdata = st_q.bus_off_sel;
            IDX_ROLE_SEL: st_d.rdata = st_q.role_sel;
            IDX_IDENT: st_d.rdata = st_q.ident;
            IDX_PERIOD: st_d.rdata = st_q.period;
            IDX_ACTION_SEL: st_d.rdata = st_q.action_sel;
            IDX_MODE_SEL: st_d.rdata = st_q.mode_sel;
            default: begin
               st_d.rdata = 16'h0000;
               st_d.err = 1'b1;
            end
         endcase
      end

      // Fault reset clears the latched fault and stop but not the alarm, the disable or the dead link
      // Ahead of bus-off handling so a new event wins
      if (fault_reset_in) begin
         st_d.fault = 1'b0;
         st_d.stop = 1'b0;
      end

      // Bus-off handling; a dead link only leaves through power-on reset
      unique case (st_q.comm)
         CST_RUN: begin
            if (bus_off_in) begin
               if (st_q.bus_off_sel == RECOVERY_AUTO) begin
                  st_d.comm = CST_RESTART;
                  st_d.restart = 1'b1;
               end else begin
                  st_d.comm = CST_DEAD;
                  // Fault replaces the alarm, other actions add to it
                  unique case (st_q.action_sel)
                     ACTION_FAULT: st_d.fault = 1'b1;
                     ACTION_STOP: begin
                        st_d.alarm = 1'b1;
                        st_d.stop = 1'b1;
                     end
                     ACTION_DISABLE: begin
                        st_d.alarm = 1'b1;
                        st_d.disable_cmd = 1'b1;
                     end
                     default: st_d.alarm = 1'b1;
                  endcase
               end
            end
         end
         CST_RESTART: begin
            // One cycle of restart, then back to normal traffic
            st_d.comm = CST_RUN;
         end
         CST_DEAD: begin
            st_d.comm = CST_DEAD;
         end
      endcase

      // Follow role drives the network state to operational while the link is not dead
      st_d.nmt_op = (producer || consumer) && (st_d.comm != CST_DEAD);
      st_d.comm_en = (st_d.comm != CST_DEAD);

      // Free running base tick
      st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;

      // Producer period timer; consumers never run it
      if (!producer || !running) begin
         st_d.period_cnt = 16'h0000;
         st_d.pend = 1'b0;
      end else if (st_q.pend) begin
         // Waits here while the queue is full, so no telegram is lost
         if (fifo_in_ready) begin
            st_d.pend = 1'b0;
            st_d.period_cnt = 16'h0000;
         end
      end else if (tick) begin
         if (st_q.period_cnt + 16'h0001 >= st_q.period) begin
            st_d.pend = 1'b1;
            st_d.frame.id = st_q.ident[10:0];
            if (st_q.role_sel == ROLE_PROD_REAL) begin
               st_d.frame.axis = real_axis_in;
            end else begin
               st_d.frame.axis = virt_axis_in;
            end
         end else begin
            st_d.period_cnt = st_q.period_cnt + 16'h0001;
         end
      end

      // Consumer path: matching identifier and ladder mode only
      if (rx_valid_in && consumer && running) begin
         if (rx_id_in == st_q.ident[10:0]) begin
            if (st_q.mode_sel == MODE_LADDER) begin
               st_d.gear_valid = 1'b1;
               st_d.gear_axis = rx_axis_in;
            end
         end
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= '0;
         st_q.bus_off_sel <= BUS_OFF_SEL_RST;
         st_q.role_sel <= ROLE_SEL_RST;
         st_q.ident <= IDENT_RST;
         st_q.period <= PERIOD_RST;
         st_q.action_sel <= ACTION_SEL_RST;
         st_q.mode_sel <= MODE_SEL_RST;
         st_q.comm <= CST_RUN;
         st_q.comm_en <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Transmit queue
   // ==========================================================
   // Queue absorbs bursts while the controller is busy with other traffic
   cfbo_fifo #(
      .WIDTH(FRAME_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .flush_in(fifo_flush),
      .in_valid_in(fifo_push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(st_q.frame),
      .out_valid_out(tx_valid_out),
      .out_ready_in(tx_ready_in),
      .out_data_out(tx_frame_out)
   );

   // ==========================================================
   // Outputs
   // ==========================================================
   // All straight from state flops
   assign par_rdata_out = st_q.rdata;
   assign par_ack_out = st_q.ack;
   assign par_err_out = st_q.err;
   assign comm_enabled_out = st_q.comm_en;
   assign can_restart_out = st_q.restart;
   assign bus_off_alarm_out = st_q.alarm;
   assign comm_fault_out = st_q.fault;
   assign stop_cmd_out = st_q.stop;
   assign disable_cmd_out = st_q.disable_cmd;
   assign nmt_operational_out = st_q.nmt_op;
   assign gear_valid_out = st_q.gear_valid;
   assign gear_axis_out = st_q.gear_axis;

endmodule // cfbo_follow_ctrl

// ### cfbo_follow_ctrl_props.sv
module cfbo_follow_ctrl_props
   import cfbo_pkg::*;
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic par_wr_in,
   input wire logic par_rd_in,
   input wire logic bus_off_in,
   input wire logic rx_valid_in,
   input wire cfbo_axis_t rx_axis_in,
   input wire logic tx_ready_in,
   input wire logic par_ack_out,
   input wire logic par_err_out,
   input wire logic tx_valid_out,
   input wire cfbo_frame_t tx_frame_out,
   input wire logic comm_enabled_out,
   input wire logic can_restart_out,
   input wire logic bus_off_alarm_out,
   input wire logic gear_valid_out,
   input wire cfbo_axis_t gear_axis_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // ==========================================================
   // Parameter port
   // ==========================================================
   ack_timing_a: assert property ((par_wr_in || par_rd_in) |=> par_ack_out)
      else $error("access without ack");
   ack_cause_a: assert property (par_ack_out |-> $past(par_wr_in || par_rd_in))
      else $error("ack without access");
   err_with_ack_a: assert property (par_err_out |-> par_ack_out)
      else $error("err outside ack");
   // ==========================================================
   // Bus-off recovery
   // ==========================================================
   restart_cause_a: assert property (can_restart_out |->
      $past(bus_off_in) && !bus_off_alarm_out)
      else $error("restart without bus-off or with alarm");
   restart_pulse_a: assert property (can_restart_out |=> !can_restart_out)
      else $error("restart longer than one cycle");
   comm_dead_a: assert property (!comm_enabled_out |=> !comm_enabled_out)
      else $error("link came back without reset");
   comm_drop_a: assert property ($fell(comm_enabled_out) |-> $past(bus_off_in))
      else $error("link dropped without bus-off");
   alarm_hold_a: assert property (bus_off_alarm_out |=> bus_off_alarm_out)
      else $error("alarm cleared without reset");
   // ==========================================================
   // Transmit and receive
   // ==========================================================
   tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
      (tx_valid_out && $stable(tx_frame_out)) || !comm_enabled_out || can_restart_out)
      else $error("frame changed while stalled");
   tx_ident_a: assert property (tx_valid_out |->
      tx_frame_out.id inside {[11'h181:11'h1ff]})
      else $error("frame identifier out of span");
   gear_cause_a: assert property (gear_valid_out |->
      $past(rx_valid_in) && gear_axis_out == $past(rx_axis_in))
      else $error("gear data not from a received frame");
endmodule // cfbo_follow_ctrl_props

bind cfbo_follow_ctrl cfbo_follow_ctrl_props u_cfbo_follow_ctrl_props (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .par_wr_in(par_wr_in), .par_rd_in(par_rd_in),
   .bus_off_in(bus_off_in), .rx_valid_in(rx_valid_in), .rx_axis_in(rx_axis_in),
   .tx_ready_in(tx_ready_in), .par_ack_out(par_ack_out), .par_err_out(par_err_out),
   .tx_valid_out(tx_valid_out), .tx_frame_out(tx_frame_out),
   .comm_enabled_out(comm_enabled_out), .can_restart_out(can_restart_out),
   .bus_off_alarm_out(bus_off_alarm_out), .gear_valid_out(gear_valid_out),
   .gear_axis_out(gear_axis_out));

// ### cfbo_can_node.sv
module cfbo_can_node
   import cfbo_pkg::*;
(
   input wire logic mclk_in,
   input wire logic stall_in,
   input wire logic tx_valid_in,
   input wire cfbo_frame_t tx_frame_in,
   output logic tx_ready_out,
   output logic rx_valid_out,
   output logic [10:0] rx_id_out,
   output cfbo_axis_t rx_axis_out
);
   timeunit 1ns;
   timeprecision 1ps;
   cfbo_frame_t got_q[$];
   time at_q[$];
   // Busy bus from other traffic holds off the queue
   assign tx_ready_out = !stall_in;
   // Log every frame taken off the queue, with its time
   always @(posedge mclk_in) begin
      if (tx_valid_in && tx_ready_out) begin
         got_q.push_back(tx_frame_in);
         at_q.push_back($time);
      end
   end
   initial begin
      rx_valid_out = 1'b0;
      rx_id_out = 11'h000;
      rx_axis_out = '0;
   end
   // One frame, then lines flipped so old data looks invalid
   task automatic send(input logic [10:0] id, input cfbo_axis_t ax);
      @(negedge mclk_in);
      rx_valid_out = 1'b1;
      rx_id_out = id;
      rx_axis_out = ax;
      @(negedge mclk_in);
      rx_valid_out = 1'b0;
      rx_id_out = ~id;
      rx_axis_out = ~ax;
   endtask
endmodule // cfbo_can_node

// ### cfbo_follow_ctrl_test.sv
module cfbo_follow_ctrl_test;
   import cfbo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Short tick keeps period tests within a few hundred cycles
   localparam int TICKS = 4;
   logic mclk_in, nrst_in, par_wr, par_rd, bus_off, fault_rst, stall;
   logic ack, err, rx_valid, tx_valid, tx_ready, comm_en, restart;
   logic alarm, fault, stop, dis, nmt, gear_v;
   logic [15:0] par_idx, par_wdata, rdata;
   logic [10:0] rx_id;
   cfbo_axis_t real_ax, virt_ax, gear_ax, rx_ax;
   cfbo_frame_t tx_frame;
   int errors = 0;
   int compares = 0;
   int cyc = 0;
   logic [15:0] ridx [6] = '{IDX_BUS_OFF_SEL, IDX_ROLE_SEL, IDX_IDENT, IDX_PERIOD,
      IDX_ACTION_SEL, IDX_MODE_SEL};
   logic [15:0] rrst [6] = '{16'h0000, 16'h0000, 16'h0181, 16'h000a, 16'h0000, 16'h0002};
   logic [15:0] bidx [9] = '{IDX_IDENT, IDX_IDENT, IDX_IDENT, IDX_IDENT, IDX_ROLE_SEL,
      IDX_ACTION_SEL, IDX_BUS_OFF_SEL, IDX_PERIOD, 16'h0000};
   logic [15:0] bdat [9] = '{16'h0180, 16'h0200, 16'h0181, 16'h01ff, 16'h0004, 16'h0004,
      16'h0002, 16'h0033, 16'h0000};
   logic berr [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

   always #10 mclk_in = ~mclk_in;

   cfbo_follow_ctrl #(.TICK_CYC(TICKS)) u_cfbo_follow_ctrl (
      .mclk_in(mclk_in), .nrst_in(nrst_in), .par_wr_in(par_wr), .par_rd_in(par_rd),
      .par_idx_in(par_idx), .par_wdata_in(par_wdata), .par_rdata_out(rdata),
      .par_ack_out(ack), .par_err_out(err), .bus_off_in(bus_off), .rx_valid_in(rx_valid),
      .rx_id_in(rx_id), .rx_axis_in(rx_ax), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
      .tx_frame_out(tx_frame), .real_axis_in(real_ax), .virt_axis_in(virt_ax),
      .fault_reset_in(fault_rst), .comm_enabled_out(comm_en), .can_restart_out(restart),
      .bus_off_alarm_out(alarm), .comm_fault_out(fault), .stop_cmd_out(stop),
      .disable_cmd_out(dis), .nmt_operational_out(nmt), .gear_valid_out(gear_v),
      .gear_axis_out(gear_ax));

   cfbo_can_node u_cfbo_can_node (
      .mclk_in(mclk_in), .stall_in(stall), .tx_valid_in(tx_valid), .tx_frame_in(tx_frame),
      .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_id_out(rx_id),
      .rx_axis_out(rx_ax));

   // ==========================================================
   // Reporting
   // ==========================================================
   task close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask
   task chk_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_axis(input cfbo_axis_t got, input cfbo_axis_t exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t axis got %h exp %h", $time, got, exp);
      end
   endtask
   // Hang guard, well above the run's length
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         close_out;
      end
   end

   // ==========================================================
   // Drivers
   // ==========================================================
   task par_io(input logic wr, input logic [15:0] idx, input logic [15:0] d, input logic e);
      @(negedge mclk_in);
      par_wr = wr;
      par_rd = !wr;
      par_idx = idx;
      par_wdata = d;
      @(negedge mclk_in);
      par_wr = 1'b0;
      par_rd = 1'b0;
      chk_bit(ack, 1'b1);
      chk_bit(err, e);
   endtask
   task do_reset;
      nrst_in = 1'b0;
      repeat (20) @(negedge mclk_in);
      nrst_in = 1'b1;
   endtask
   task hit_bus_off;
      @(negedge mclk_in);
      bus_off = 1'b1;
      @(negedge mclk_in);
      bus_off = 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task t_regs;
      for (int i = 0; i < 6; i++) begin
         par_io(1'b0, ridx[i], 16'h0000, 1'b0);
         chk_word(rdata, rrst[i]);
      end
      for (int i = 0; i < 9; i++) begin
         par_io(1'b1, bidx[i], bdat[i], berr[i]);
      end
      par_io(1'b0, IDX_IDENT, 16'h0000, 1'b0);
      chk_word(rdata, 16'h01ff);
   endtask
   task t_produce(input logic [15:0] role, input cfbo_axis_t exp);
      int gap;
      par_io(1'b1, IDX_IDENT, 16'h01a5, 1'b0);
      par_io(1'b1, IDX_PERIOD, 16'h0002, 1'b0);
      u_cfbo_can_node.got_q.delete();
      u_cfbo_can_node.at_q.delete();
      par_io(1'b1, IDX_ROLE_SEL, role, 1'b0);
      for (int i = 0; i < 300 && u_cfbo_can_node.got_q.size() < 5; i++) @(negedge mclk_in);
      chk_bit(nmt, 1'b1);
      chk_bit(u_cfbo_can_node.got_q.size() >= 5, 1'b1);
      for (int k = 2; k < 5 && k < u_cfbo_can_node.got_q.size(); k++) begin
         gap = int'((u_cfbo_can_node.at_q[k] - u_cfbo_can_node.at_q[k-1]) / 20);
         chk_word({5'h00, u_cfbo_can_node.got_q[k].id}, 16'h01a5);
         chk_axis(u_cfbo_can_node.got_q[k].axis, exp);
         chk_bit(gap >= 2 * TICKS && gap <= 2 * TICKS + 1, 1'b1);
      end
   endtask
   task t_fill;
      @(negedge mclk_in);
      stall = 1'b1;
      repeat (120) @(negedge mclk_in);
      chk_bit(tx_valid, 1'b1);
      u_cfbo_can_node.got_q.delete();
      stall = 1'b0;
      repeat (20) @(negedge mclk_in);
      chk_bit(u_cfbo_can_node.got_q.size() >= FIFO_DEPTH + 1, 1'b1);
   endtask
   task t_consume;
      par_io(1'b1, IDX_ROLE_SEL, ROLE_CONSUMER, 1'b0);
      par_io(1'b1, IDX_MODE_SEL, MODE_LADDER, 1'b0);
      par_io(1'b1, IDX_PERIOD, 16'h0032, 1'b0);
      chk_bit(nmt, 1'b1);
      u_cfbo_can_node.send(11'h1a5, {32'h0000_5a5a, 32'h0000_0077});
      chk_bit(gear_v, 1'b1);
      chk_axis(gear_ax, {32'h0000_5a5a, 32'h0000_0077});
      u_cfbo_can_node.send(11'h1a6, {32'h0000_1234, 32'h0000_0011});
      chk_bit(gear_v, 1'b0);
      par_io(1'b1, IDX_MODE_SEL, 16'h0002, 1'b0);
      u_cfbo_can_node.send(11'h1a5, {32'h0000_1234, 32'h0000_0011});
      chk_bit(gear_v, 1'b0);
      chk_axis(gear_ax, {32'h0000_5a5a, 32'h0000_0077});
   endtask
   task t_auto;
      do_reset;
      par_io(1'b1, IDX_BUS_OFF_SEL, RECOVERY_AUTO, 1'b0);
      par_io(1'b1, IDX_ACTION_SEL, ACTION_STOP, 1'b0);
      hit_bus_off;
      chk_bit(restart, 1'b1);
      repeat (2) @(negedge mclk_in);
      chk_bit(alarm | stop | fault, 1'b0);
      chk_bit(comm_en, 1'b1);
   endtask
   task t_manual(input logic [15:0] a);
      do_reset;
      par_io(1'b1, IDX_ACTION_SEL, a, 1'b0);
      par_io(1'b1, IDX_ROLE_SEL, ROLE_PROD_REAL, 1'b0);
      hit_bus_off;
      repeat (2) @(negedge mclk_in);
      chk_bit(comm_en | nmt | restart, 1'b0);
      chk_word({alarm, fault, stop, dis}, {a != ACTION_FAULT, a == ACTION_FAULT,
         a == ACTION_STOP, a == ACTION_DISABLE});
      fault_rst = 1'b1;
      @(negedge mclk_in);
      fault_rst = 1'b0;
      repeat (20) @(negedge mclk_in);
      chk_word({alarm, fault, stop, dis, tx_valid, comm_en}, {a != ACTION_FAULT, 2'b00,
         a == ACTION_DISABLE, 2'b00});
   endtask

   initial begin
      mclk_in = 1'b0;
      {par_wr, par_rd, bus_off, fault_rst, stall} = 5'h00;
      par_idx = 16'h0000;
      par_wdata = 16'h0000;
      real_ax = {32'h1111_0001, 32'h2222_0002};
      virt_ax = {32'h3333_0003, 32'h4444_0004};
      do_reset;
      t_regs;
      t_produce(ROLE_PROD_REAL, real_ax);
      t_produce(ROLE_PROD_VIRT, virt_ax);
      t_fill;
      t_consume;
      t_auto;
      for (int a = 0; a < 4; a++) begin
         t_manual(16'(a));
      end
      close_out;
   end
endmodule // cfbo_follow_ctrl_test
